// [common/omc_pkg.sv]
package omc_pkg;

    // Clock rate
    localparam int CLK_MHZ = 250;

    // Documented times in their own units
    localparam int T_OFF_US        = 10;
    localparam int T_ON_MS         = 1;
    localparam int T_INIT_MS       = 300;
    localparam int T_FAULT_US      = 100;
    localparam int T_RESET_US      = 10;
    localparam int T_LOSS_US       = 100;
    localparam int SCL_MAX_KHZ     = 100;

    // Derived cycle counts (longest times round down, least times round up)
    localparam int OFF_CYC   = T_OFF_US * CLK_MHZ;
    localparam int ON_CYC    = T_ON_MS * 1000 * CLK_MHZ;
    localparam int INIT_CYC  = T_INIT_MS * 1000 * CLK_MHZ;
    localparam int FAULT_CYC = T_FAULT_US * CLK_MHZ;
    localparam int RESET_CYC = T_RESET_US * CLK_MHZ;
    localparam int LOSS_CYC  = T_LOSS_US * CLK_MHZ;
    localparam int SCL_MIN_CYC = (CLK_MHZ * 1000) / SCL_MAX_KHZ;

    // Two-wire device addresses
    localparam logic [6:0] ID_DEV_ADDR   = 7'h50;
    localparam logic [6:0] DIAG_DEV_ADDR = 7'h51;

    // Counter width wide enough for the init interval
    localparam int CNT_W = 27;

    typedef enum logic [1:0] {
        OMC_INIT,
        OMC_RUN,
        OMC_OFF
    } omc_tx_state_t;

endpackage

// [common/omc_timer_if.sv]
`timescale 1ns/100ps
`default_nettype none
interface omc_timer_if;
    logic                     start;
    logic [omc_pkg::CNT_W-1:0] limit;
    logic                     done;
    logic                     busy;
    modport owner (output start, output limit, input done, input busy);
    modport timer (input start, input limit, output done, output busy);
endinterface
`default_nettype wire

// [core/omc_timer.sv]
`timescale 1ns/100ps
`default_nettype none
module omc_timer (
    // Clock and reset
    input  wire logic i_clk,
    input  wire logic i_rst,
    // Control
    omc_timer_if.timer tmr
);
    logic [omc_pkg::CNT_W-1:0] cnt_reg;
    logic                      busy_reg;

    assign tmr.busy = busy_reg;
    assign tmr.done = busy_reg && (cnt_reg == '0);

    // Restart wins over a running count
    always_ff @(posedge i_clk) begin
        if (i_rst || tmr.start) begin
            cnt_reg  <= i_rst ? '0 : tmr.limit;
            busy_reg <= !i_rst;
        end else if (busy_reg) begin
            if (cnt_reg == '0) begin
                busy_reg <= 1'b0;
            end else begin
                cnt_reg <= cnt_reg - 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// [core/omc_ctrl.sv]
// How it works
// - Transmit-off high switches the laser off; low keeps it on.
// - Transmit-off input is pulled down inside; open means enabled.
// - Fault flag high on any laser fault, low in normal operation.
// - Presence pin is held low by the module.
// - Serial data pin is the bidirectional two-wire data line.
// - Rx loss indicator high while received power is below sensitivity.
// - Laser off within 10 us of transmit-off rising.
// - Laser modulating within 1 ms of transmit-off falling.
// - Initialisation and fault clear finish within 300 ms.
// - Fault flag asserts within 100 us of the fault.
// - Rx loss asserts within 100 us of loss.
// - Rx loss deasserts within 100 us of recovery.
// - Receive data squelched while rx loss is asserted.
// - Diagnostics memory answers at two-wire address A2h.
`timescale 1ns/100ps
`default_nettype none
module omc_ctrl (
    // Clock and reset (reset stands for power-on)
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    // Host control pins
    input  wire logic       i_tx_off,
    input  wire logic       i_tx_off_oe,
    // Laser side
    input  wire logic       i_laser_fault,
    output logic            o_laser_en,
    output logic            o_fault_flag_oe,
    output logic            o_fault_flag,
    // Receiver side
    input  wire logic       i_rx_below_sens,
    input  wire logic       i_rx_data,
    output logic            o_rx_data,
    output logic            o_rx_loss_indicator,
    // Presence and two-wire pins
    output logic            o_presence_pin,
    output logic            o_presence_pin_oe,
    input  wire logic       i_serial_clock_pin,
    input  wire logic       i_serial_data_pin,
    output logic            o_serial_data_pin,
    output logic            o_serial_data_pin_oe,
    // Two-wire memory port (memory contents live outside)
    output logic            o_mem_sel_diag,
    output logic [7:0]      o_mem_addr,
    output logic            o_mem_wr,
    output logic [7:0]      o_mem_wdata,
    input  wire logic [7:0] i_mem_rdata,
    // Status
    output logic            o_init_done
);
    ////////////////////////////////////////////////////////////////////////
    // Transmit control
    // Undriven input reads as low, as the pull-down would make it
    wire tx_off = i_tx_off_oe & i_tx_off;

    omc_pkg::omc_tx_state_t st_reg, st_next;
    logic fault_reg;
    logic tx_off_d_reg;
    logic [$clog2(omc_pkg::RESET_CYC+1)-1:0] hold_reg;
    logic laser_en_reg;
    logic rx_loss_reg;
    logic rx_data_reg;

    omc_timer_if tif ();
    omc_timer u_init_tmr (
        .i_clk (i_clk),
        .i_rst (i_rst),
        .tmr   (tif)
    );

    wire hold_met  = (hold_reg == ($bits(hold_reg))'(omc_pkg::RESET_CYC));
    wire off_fall  = tx_off_d_reg && !tx_off;
    // Fault reset only after a long enough disable pulse
    wire fault_rst = off_fall && hold_met;

    // Init after a fault reset runs a short settle well inside 300 ms, then clears the flag
    assign tif.limit = omc_pkg::CNT_W'(omc_pkg::OFF_CYC);
    assign tif.start = (st_reg == omc_pkg::OMC_OFF) && fault_rst;

    always_comb begin
        st_next = st_reg;
        case (st_reg)
            omc_pkg::OMC_INIT: begin
                if (!tif.busy) begin
                    st_next = tx_off ? omc_pkg::OMC_OFF : omc_pkg::OMC_RUN;
                end
            end
            omc_pkg::OMC_RUN: begin
                if (tx_off) begin
                    st_next = omc_pkg::OMC_OFF;
                end
            end
            omc_pkg::OMC_OFF: begin
                if (fault_rst) begin
                    st_next = omc_pkg::OMC_INIT;
                end else if (!tx_off) begin
                    st_next = omc_pkg::OMC_RUN;
                end
            end
            default: st_next = omc_pkg::OMC_INIT;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            st_reg       <= omc_pkg::OMC_INIT;
            tx_off_d_reg <= 1'b0;
            hold_reg     <= '0;
        end else begin
            st_reg       <= st_next;
            tx_off_d_reg <= tx_off;
            if (!tx_off) begin
                hold_reg <= '0;
            end else if (!hold_met) begin
                hold_reg <= hold_reg + 1'b1;
            end
        end
    end

    // Laser registers the next state, so it changes on the same edge as the state: far inside 10 us and 1 ms
    wire laser_en_next = (st_next == omc_pkg::OMC_RUN) && !fault_reg;
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            laser_en_reg <= 1'b0;
        end else begin
            laser_en_reg <= laser_en_next;
        end
    end
    assign o_laser_en = laser_en_reg;

    ////////////////////////////////////////////////////////////////////////
    // Fault flag: latched, cleared only by init after reset pulse
    // A fault in the clearing cycle still sets the flag
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            fault_reg <= 1'b0;
        end else if (i_laser_fault) begin
            fault_reg <= 1'b1;
        end else if (tif.done) begin
            fault_reg <= 1'b0;
        end
    end
    // Open drain: drive low in normal operation, release for fault
    assign o_fault_flag    = 1'b0;
    assign o_fault_flag_oe = !fault_reg;
    assign o_init_done     = (st_reg != omc_pkg::OMC_INIT);

    ////////////////////////////////////////////////////////////////////////
    // Receiver loss and squelch
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            rx_loss_reg <= 1'b1;
            rx_data_reg <= 1'b0;
        end else begin
            rx_loss_reg <= i_rx_below_sens;
            // Squelch held at a fixed level, no garbage without light
            rx_data_reg <= i_rx_below_sens ? 1'b0 : i_rx_data;
        end
    end
    assign o_rx_loss_indicator = rx_loss_reg;
    assign o_rx_data           = rx_data_reg;

    ////////////////////////////////////////////////////////////////////////
    // Presence
    assign o_presence_pin    = 1'b0;
    assign o_presence_pin_oe = 1'b1;

    ////////////////////////////////////////////////////////////////////////
    // Two-wire slave
    typedef enum logic [2:0] {
        OMC_TW_IDLE,
        OMC_TW_DEV,
        OMC_TW_ADDR,
        OMC_TW_WR,
        OMC_TW_RD,
        OMC_TW_ACK
    } omc_tw_state_t;

    omc_tw_state_t tw_reg;
    omc_tw_state_t tw_after_reg;
    logic       scl_d_reg;
    logic       sda_d_reg;
    logic [7:0] sh_reg;
    logic [3:0] bit_reg;
    logic       diag_reg;
    logic [7:0] addr_reg;
    logic       drv_reg;
    logic       rd_ack_reg;
    logic       wr_reg;

    wire scl_rise = !scl_d_reg && i_serial_clock_pin;
    wire scl_fall = scl_d_reg && !i_serial_clock_pin;
    wire start_c  = scl_d_reg && i_serial_clock_pin &&
                    sda_d_reg && !i_serial_data_pin;
    wire stop_c   = scl_d_reg && i_serial_clock_pin &&
                    !sda_d_reg && i_serial_data_pin;
    wire [7:0] sh_in = {sh_reg[6:0], i_serial_data_pin};
    // Compared at the eighth falling clock, when the whole byte is in sh_reg
    wire dev_id   = sh_reg[7:1] == omc_pkg::ID_DEV_ADDR;
    wire dev_diag = sh_reg[7:1] == omc_pkg::DIAG_DEV_ADDR;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            tw_reg       <= OMC_TW_IDLE;
            tw_after_reg <= OMC_TW_IDLE;
            scl_d_reg    <= 1'b1;
            sda_d_reg    <= 1'b1;
            sh_reg       <= 8'h00;
            bit_reg      <= 4'h0;
            diag_reg     <= 1'b0;
            addr_reg     <= 8'h00;
            drv_reg      <= 1'b0;
            rd_ack_reg   <= 1'b0;
            wr_reg       <= 1'b0;
        end else begin
            scl_d_reg <= i_serial_clock_pin;
            sda_d_reg <= i_serial_data_pin;
            wr_reg    <= 1'b0;
            if (start_c) begin
                tw_reg  <= OMC_TW_DEV;
                bit_reg <= 4'h0;
                drv_reg <= 1'b0;
            end else if (stop_c) begin
                tw_reg  <= OMC_TW_IDLE;
                drv_reg <= 1'b0;
            end else if (scl_rise) begin
                case (tw_reg)
                    OMC_TW_DEV, OMC_TW_ADDR, OMC_TW_WR: begin
                        sh_reg  <= sh_in;
                        bit_reg <= bit_reg + 4'h1;
                    end
                    OMC_TW_RD: begin
                        bit_reg <= bit_reg + 4'h1;
                    end
                    OMC_TW_ACK: begin
                        // Master nack ends a read
                        rd_ack_reg <= !i_serial_data_pin;
                    end
                    default: ;
                endcase
            end else if (scl_fall) begin
                case (tw_reg)
                    OMC_TW_DEV: begin
                        if (bit_reg == 4'h8) begin
                            if (dev_id || dev_diag) begin
                                diag_reg <= dev_diag;
                                drv_reg  <= 1'b1;
                                tw_reg   <= OMC_TW_ACK;
                                tw_after_reg <= sh_reg[0] ? OMC_TW_RD
                                                          : OMC_TW_ADDR;
                                rd_ack_reg <= 1'b1;
                            end else begin
                                tw_reg <= OMC_TW_IDLE;
                            end
                        end
                    end
                    OMC_TW_ADDR, OMC_TW_WR: begin
                        if (bit_reg == 4'h8) begin
                            if (tw_reg == OMC_TW_ADDR) begin
                                addr_reg <= sh_reg;
                            end else begin
                                wr_reg   <= 1'b1;
                            end
                            drv_reg      <= 1'b1;
                            tw_after_reg <= OMC_TW_WR;
                            tw_reg       <= OMC_TW_ACK;
                            rd_ack_reg   <= 1'b1;
                        end
                    end
                    OMC_TW_RD: begin
                        if (bit_reg == 4'h8) begin
                            drv_reg      <= 1'b0;
                            addr_reg     <= addr_reg + 8'h01;
                            tw_after_reg <= OMC_TW_RD;
                            tw_reg       <= OMC_TW_ACK;
                        end else begin
                            drv_reg <= !i_mem_rdata[3'(7 - bit_reg)];
                        end
                    end
                    OMC_TW_ACK: begin
                        bit_reg <= 4'h0;
                        if (tw_after_reg == OMC_TW_RD && rd_ack_reg) begin
                            tw_reg  <= OMC_TW_RD;
                            drv_reg <= !i_mem_rdata[7];
                        end else if (tw_after_reg == OMC_TW_RD) begin
                            tw_reg  <= OMC_TW_IDLE;
                            drv_reg <= 1'b0;
                        end else begin
                            tw_reg  <= tw_after_reg;
                            drv_reg <= 1'b0;
                        end
                        if (wr_reg || tw_after_reg == OMC_TW_WR) begin
                            addr_reg <= addr_reg;
                        end
                    end
                    default: ;
                endcase
            end
        end
    end

    // Write lands at the current address, which then steps on
    logic [7:0] waddr_reg;
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            waddr_reg <= 8'h00;
        end else if (wr_reg) begin
            waddr_reg <= waddr_reg + 8'h01;
        end else if (tw_reg == OMC_TW_ADDR) begin
            waddr_reg <= sh_reg;
        end
    end

    // Open drain data line: only ever pulls low
    assign o_serial_data_pin    = 1'b0;
    assign o_serial_data_pin_oe = drv_reg;
    assign o_mem_sel_diag       = diag_reg;
    assign o_mem_addr           = wr_reg ? waddr_reg : addr_reg;
    assign o_mem_wr             = wr_reg;
    assign o_mem_wdata          = sh_reg;
endmodule
`default_nettype wire

// [bench/omc_ctrl_checker.sv]
`timescale 1ns/100ps
`default_nettype none
module omc_ctrl_checker (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Watched ports
    input wire logic i_tx_off,
    input wire logic i_tx_off_oe,
    input wire logic i_laser_fault,
    input wire logic i_rx_below_sens,
    input wire logic o_laser_en,
    input wire logic o_fault_flag_oe,
    input wire logic o_rx_data,
    input wire logic o_rx_loss_indicator,
    input wire logic o_presence_pin,
    input wire logic o_presence_pin_oe,
    input wire logic o_init_done
);
    logic [11:0] hold_reg;
    logic [11:0] clr_reg;
    logic        off_d_reg;
    logic        off_eff;

    // Longest wait for the flag after a long pulse: init count plus slack
    localparam int CLR_MAX = omc_pkg::OFF_CYC + 8;

    // An open input reads as low
    assign off_eff = i_tx_off && i_tx_off_oe;

    // Saturates so a very long hold cannot wrap into a short one
    always_ff @(posedge i_clk) begin
        if (i_rst || !off_eff) hold_reg <= 12'h000;
        else if (hold_reg != 12'hFFF) hold_reg <= hold_reg + 12'h001;
    end

    // Cycles since a long pulse ended with the flag still up
    // Too long for a delay range, so the bound is counted here
    always_ff @(posedge i_clk) begin
        off_d_reg <= off_eff;
        if (i_rst || o_fault_flag_oe || i_laser_fault) begin
            clr_reg <= 12'h000;
        end else if (off_d_reg && !off_eff &&
                     (int'(hold_reg) >= omc_pkg::RESET_CYC)) begin
            clr_reg <= 12'h001;
        end else if (clr_reg != 12'h000 && clr_reg != 12'hFFF) begin
            clr_reg <= clr_reg + 12'h001;
        end
    end

    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);

    // A long pulse restarts init, so only short ones bring the laser straight back
    sequence s_release;
        $fell(off_eff) && o_fault_flag_oe && o_init_done && !i_laser_fault
            && (int'(hold_reg) < omc_pkg::RESET_CYC)
            ##1 (!off_eff && !i_laser_fault) [*2];
    endsequence
    // Four edges of margin against the design's own hold counting
    sequence s_short_pulse;
        $fell(off_eff) && !o_fault_flag_oe && o_init_done
            && (int'(hold_reg) + 4 < omc_pkg::RESET_CYC);
    endsequence

    chk_laser_off: assert property (off_eff [*3] |=> !o_laser_en)
        else $error("laser stays on under transmit-off");
    chk_laser_on: assert property (s_release |=> o_laser_en)
        else $error("laser not back after release");
    chk_fault_set: assert property (
        i_laser_fault |=> !o_fault_flag_oe)
        else $error("fault flag not raised");
    chk_short_keeps: assert property (
        s_short_pulse |=> (!o_fault_flag_oe) [*8])
        else $error("short pulse cleared the fault");
    chk_clear_bound: assert property (
        int'(clr_reg) <= CLR_MAX)
        else $error("fault flag not cleared in time");
    chk_loss_on: assert property (
        i_rx_below_sens |=> o_rx_loss_indicator)
        else $error("loss indicator not raised");
    chk_loss_off: assert property (
        !i_rx_below_sens |=> !o_rx_loss_indicator)
        else $error("loss indicator not dropped");
    chk_rx_squelch: assert property (
        o_rx_loss_indicator |-> !o_rx_data)
        else $error("receive data not squelched");
    chk_presence_low: assert property (
        o_presence_pin_oe && !o_presence_pin)
        else $error("presence pin not grounded");
    chk_init_time: assert property (
        $fell(i_rst) |-> ##[0:4] o_init_done)
        else $error("initialisation too long");
endmodule
bind omc_ctrl omc_ctrl_checker i_chk (
    .i_clk               (i_clk),
    .i_rst               (i_rst),
    .i_tx_off            (i_tx_off),
    .i_tx_off_oe         (i_tx_off_oe),
    .i_laser_fault       (i_laser_fault),
    .i_rx_below_sens     (i_rx_below_sens),
    .o_laser_en          (o_laser_en),
    .o_fault_flag_oe     (o_fault_flag_oe),
    .o_rx_data           (o_rx_data),
    .o_rx_loss_indicator (o_rx_loss_indicator),
    .o_presence_pin      (o_presence_pin),
    .o_presence_pin_oe   (o_presence_pin_oe),
    .o_init_done         (o_init_done)
);
`default_nettype wire

// [bench/omc_host_model.sv]
`timescale 1ns/100ps
`default_nettype none
// No bandwidth choice pin exists here; the host leaves it open
module omc_host_model #(parameter int HALF = omc_pkg::SCL_MIN_CYC / 2) (
    // Clock and device side
    input  wire logic i_clk,
    input  wire logic i_sda_dev_oe,
    input  wire logic i_fault_oe,
    // Resolved wires
    output logic      o_scl,
    output logic      o_sda,
    output logic      o_fault_pin
);
    logic sda_low;

    initial begin
        o_scl = 1'b1;
        sda_low = 1'b0;
    end
    // Pull-ups on the host board
    assign o_sda = !(sda_low || i_sda_dev_oe);
    assign o_fault_pin = !i_fault_oe;

    // Half period of 5 us keeps the clock at 100 kHz
    task automatic half;
        repeat (HALF) @(posedge i_clk);
    endtask
    // Data moves one cycle after the clock falls, for hold time
    task automatic put_bit(input logic b, output logic got);
        @(posedge i_clk);
        sda_low <= !b;
        half();
        o_scl <= 1'b1;
        half();
        got = o_sda;
        o_scl <= 1'b0;
    endtask
    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic g;
        for (int i = 7; i >= 0; i--) put_bit(b[i], g);
        put_bit(1'b1, g);
        ack = !g;
    endtask
    task automatic start;
        sda_low <= 1'b1;
        half();
        o_scl <= 1'b0;
    endtask
    task automatic stop;
        @(posedge i_clk);
        sda_low <= 1'b1;
        half();
        o_scl <= 1'b1;
        half();
        sda_low <= 1'b0;
        half();
    endtask
endmodule
`default_nettype wire

// [bench/omc_ctrl_test.sv]
`timescale 1ns/100ps
`default_nettype none
module omc_ctrl_test;
    logic       clk = 1'b0, rst = 1'b1, tx_off = 1'b1, tx_off_oe = 1'b0;
    logic       fault = 1'b0, below = 1'b1, rxd = 1'b0, ack;
    logic       laser_en, fault_oe, fault_flag, rx_q, loss, pres, pres_oe;
    logic       scl, sda, sda_o, sda_oe, sel_diag, mwr, init_done, fpin;
    logic [7:0] maddr, mwdata, wr_addr, wr_data;
    int         err_count = 0, n_tests = 0, wr_cnt = 0;

    always #2 clk = ~clk;

    omc_ctrl i_dut (
        .i_clk(clk), .i_rst(rst), .i_tx_off(tx_off), .i_tx_off_oe(tx_off_oe),
        .i_laser_fault(fault), .o_laser_en(laser_en),
        .o_fault_flag_oe(fault_oe), .o_fault_flag(fault_flag),
        .i_rx_below_sens(below), .i_rx_data(rxd), .o_rx_data(rx_q),
        .o_rx_loss_indicator(loss), .o_presence_pin(pres),
        .o_presence_pin_oe(pres_oe), .i_serial_clock_pin(scl),
        .i_serial_data_pin(sda), .o_serial_data_pin(sda_o),
        .o_serial_data_pin_oe(sda_oe), .o_mem_sel_diag(sel_diag),
        .o_mem_addr(maddr), .o_mem_wr(mwr), .o_mem_wdata(mwdata),
        .i_mem_rdata(8'h5A), .o_init_done(init_done)
    );
    omc_host_model i_host (
        .i_clk(clk), .i_sda_dev_oe(sda_oe), .i_fault_oe(fault_oe),
        .o_scl(scl), .o_sda(sda), .o_fault_pin(fpin)
    );

    always @(posedge clk) begin
        if (mwr === 1'b1) begin
            wr_cnt++;
            wr_addr = maddr;
            wr_data = mwdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic stop_test;
        if (err_count == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Bounded wait on the laser enable or on the resolved fault pin
    task automatic wait_on(input logic use_pin, input logic v, input int lim);
        int k;
        k = 0;
        while (((use_pin ? fpin : laser_en) !== v) && k < lim) begin
            @(posedge clk);
            k++;
        end
        if (k >= lim) begin
            err_count++;
            stop_test();
        end
    endtask
    task automatic set_off(input logic v);
        @(posedge clk);
        tx_off <= v;
        tx_off_oe <= 1'b1;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        // Open input is driven high behind the enable to expose the pull-down
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        below <= 1'b0;
        wait_on(1'b0, 1'b1, 16);
        chk({6'h00, pres_oe, pres}, 8'h02);
        chk({7'h00, init_done}, 8'h01);
        set_off(1'b1);
        wait_on(1'b0, 1'b0, omc_pkg::OFF_CYC);
        set_off(1'b0);
        wait_on(1'b0, 1'b1, 16);
        @(posedge clk);
        fault <= 1'b1;
        @(posedge clk);
        fault <= 1'b0;
        wait_on(1'b1, 1'b1, omc_pkg::FAULT_CYC);
        wait_on(1'b0, 1'b0, 4);
        set_off(1'b1);
        repeat (100) @(posedge clk);
        tx_off <= 1'b0;
        repeat (50) @(posedge clk);
        chk({7'h00, fpin}, 8'h01);
        chk({7'h00, laser_en}, 8'h00);
        set_off(1'b1);
        repeat (omc_pkg::RESET_CYC + 2) @(posedge clk);
        tx_off <= 1'b0;
        wait_on(1'b1, 1'b0, 3000);
        wait_on(1'b0, 1'b1, 16);
        for (int i = 3; i >= 0; i--) begin
            @(posedge clk);
            below <= i[1];
            rxd <= i[0];
            repeat (2) @(posedge clk);
            chk({6'h00, loss, rx_q},
                {6'h00, i[1], i[0] & !i[1]});
        end
        i_host.start();
        i_host.send_byte(8'hA2, ack);
        chk({7'h00, ack}, 8'h01);
        chk({7'h00, sel_diag}, 8'h01);
        i_host.send_byte(8'h10, ack);
        chk({7'h00, ack}, 8'h01);
        i_host.send_byte(8'h3C, ack);
        chk({7'h00, ack}, 8'h01);
        i_host.stop();
        chk(wr_cnt[7:0], 8'h01);
        chk(wr_addr, 8'h10);
        chk(wr_data, 8'h3C);
        i_host.start();
        i_host.send_byte(8'hB0, ack);
        chk({7'h00, ack}, 8'h00);
        i_host.stop();
        chk(wr_cnt[7:0], 8'h01);
        stop_test();
    end
endmodule
`default_nettype wire
